// ===== common/cxd_pkg.sv
// package: opcodes, register offsets, field layouts and reset values for the exec block
package cxd_pkg;
    // register byte offsets on the bus
    localparam logic [3:0] CXD_OFF_INSN = 4'h0;
    localparam logic [3:0] CXD_OFF_ACC = 4'h4;
    localparam logic [3:0] CXD_OFF_STATUS = 4'h8;
    localparam logic [3:0] CXD_OFF_PC = 4'hc;
    // status field positions
    localparam int CXD_ZERO_BIT = 0;
    localparam int CXD_SLEEP_BIT = 1;
    localparam int CXD_EXPIRY_BIT = 2;
    localparam int CXD_BUSY_BIT = 3;
    localparam int CXD_LATCH_LSB = 8;
    // reset values
    localparam logic [7:0] CXD_ACC_RST = 8'h00;
    localparam logic [12:0] CXD_PC_RST = 13'h0000;
    localparam logic [7:0] CXD_LATCH_RST = 8'h00;
    localparam logic [7:0] CXD_ZERO8 = 8'h00;
    localparam logic [7:0] CXD_ONE8 = 8'h01;
    localparam logic [12:0] CXD_ONE13 = 13'h0001;
    localparam int CXD_FILE_DEPTH = 128;
    localparam int CXD_STACK_DEPTH = 8;

    // operation codes written by software into the instruction register
    typedef enum logic [2:0] {
        CXD_OP_NOP,
        CXD_OP_WDT_CLEAR,
        CXD_OP_CALL,
        CXD_OP_COMPLEMENT,
        CXD_OP_CLEAR_FILE,
        CXD_OP_DECREMENT,
        CXD_OP_CLEAR_ACC,
        CXD_OP_DEC_SKIP
    } cxd_op_t;

    // decoded instruction word: op[22:20] dest[19] file[18:12] target[10:0]
    typedef struct packed {
        cxd_op_t op;
        logic dest;
        logic [6:0] file_addr;
        logic pad;
        logic [10:0] target;
    } cxd_insn_t;

    // result of one execution step
    typedef struct packed {
        logic [7:0] value;
        logic to_file;
        logic to_acc;
        logic zero_upd;
        logic skip;
    } cxd_result_t;
endpackage : cxd_pkg

// ===== verilog/cxd_alu.sv
// combinational file-operand datapath for complement, clear and decrement
`timescale 1ns/10ps
`default_nettype none
module cxd_alu
    import cxd_pkg::*;
(
    input wire cxd_op_t op,
    input wire logic dest,
    input wire logic [7:0] operand,
    output cxd_result_t res
);
    wire logic [7:0] dec_val = operand - CXD_ONE8;
    wire logic file_op = (op == CXD_OP_COMPLEMENT) || (op == CXD_OP_DECREMENT)
        || (op == CXD_OP_DEC_SKIP);
    // value per op; clear ops yield zero
    wire logic [7:0] value = (op == CXD_OP_COMPLEMENT) ? ~operand :
        ((op == CXD_OP_DECREMENT) || (op == CXD_OP_DEC_SKIP)) ? dec_val : CXD_ZERO8;
    // dest 0 -> accumulator, 1 -> file register
    assign res.value = value;
    assign res.to_file = (file_op && dest) || (op == CXD_OP_CLEAR_FILE); // [RULE7] [RULE8]
    assign res.to_acc = (file_op && !dest) || (op == CXD_OP_CLEAR_ACC); // [RULE7] [RULE10]
    // decrement-skip alters no flag, so it stays out of the zero update
    assign res.zero_upd = (op == CXD_OP_COMPLEMENT) || (op == CXD_OP_DECREMENT)
        || (op == CXD_OP_CLEAR_FILE) || (op == CXD_OP_CLEAR_ACC); // [RULE6] [RULE9] [RULE11]
    assign res.skip = (op == CXD_OP_DEC_SKIP) && (dec_val == CXD_ZERO8); // [RULE12]
endmodule : cxd_alu
`default_nettype wire

// ===== verilog/cxd_stack.sv
// eight-entry circular return-address stack
`timescale 1ns/10ps
`default_nettype none
module cxd_stack
    import cxd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [12:0] push_addr,
    output logic [12:0] top
);
    logic [12:0] mem [CXD_STACK_DEPTH];
    logic [2:0] sp_r;
    // top is the last pushed entry; overflow wraps, like a small hardware stack
    assign top = mem[sp_r - 3'h1];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sp_r <= 3'h0;
        end else if (push) begin
            sp_r <= sp_r + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[sp_r] <= push_addr;
        end
    end
endmodule : cxd_stack
`default_nettype wire

// ===== verilog/cxd_exec.sv
// execution unit for watchdog clear, call, complement, clear and decrement ops
//==========================================================================
// How it works
// RULE1 - watchdog clear zeroes counter and prescaler
// RULE2 - watchdog clear sets expiry and sleep flags
// RULE3 - call pushes pc plus one first
// RULE4 - call loads 11-bit target, latch bits 4:3
// RULE5 - call takes two cycles, flags kept
// RULE6 - complement writes inverse, zero flag only
// RULE7 - 7-bit file address, dest bit selects target
// RULE8 - clear file writes zero, sets zero flag
// RULE9 - decrement subtracts one, zero flag only
// RULE10 - clear accumulator zeroes it, sets zero flag
// RULE11 - decrement-skip alters no status flag
// RULE12 - zero result skips next, two cycles
// RULE13 - zero flag set iff result all zero
// RULE14 - other ops finish in one cycle
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cxd_exec
    import cxd_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // watchdog
    output logic WDT_CLEAR,
    output logic WDT_PRESCALER_CLEAR,
    // program counter and stack top
    output logic [12:0] PC,
    output logic [12:0] STACK_TOP
);
    //======================================================================
    // state and registers
    typedef enum logic [1:0] {CXD_IDLE, CXD_EXEC, CXD_SECOND} cxd_state_t;
    cxd_state_t state_r, state_nxt;
    cxd_insn_t insn_r;
    logic [7:0] acc_r;
    logic [7:0] latch_r;
    logic [12:0] pc_r;
    logic zero_r, sleep_r, expiry_r;
    // file registers carry no reset; software runs clear file on them first
    logic [7:0] file_mem [CXD_FILE_DEPTH];
    logic [31:0] rdata_r;
    logic rvalid_r;

    //======================================================================
    // bus decode
    wire logic hit_insn = AVS_ADDRESS == CXD_OFF_INSN;
    wire logic hit_acc = AVS_ADDRESS == CXD_OFF_ACC;
    wire logic hit_status = AVS_ADDRESS == CXD_OFF_STATUS;
    wire logic hit_pc = AVS_ADDRESS == CXD_OFF_PC;
    wire logic busy = state_r != CXD_IDLE;
    // writes wait while an op runs; reads take one wait cycle for registered data
    wire logic wr_take = AVS_WRITE && !busy;
    wire logic rd_take = AVS_READ && rvalid_r;
    assign AVS_WAITREQUEST = (AVS_WRITE && !wr_take) || (AVS_READ && !rd_take);
    assign AVS_READDATA = rdata_r;
    wire logic start = wr_take && hit_insn && AVS_BYTEENABLE[2];
    wire cxd_insn_t new_insn = cxd_insn_t'(AVS_WRITEDATA[22:0]);

    //======================================================================
    // datapath
    cxd_result_t res;
    wire logic [7:0] operand = file_mem[insn_r.file_addr]; // [RULE7]
    cxd_alu u_alu (
        .op(insn_r.op),
        .dest(insn_r.dest),
        .operand(operand),
        .res(res)
    );
    wire logic exec = state_r == CXD_EXEC;
    wire logic is_call = exec && (insn_r.op == CXD_OP_CALL);
    wire logic is_wdt = exec && (insn_r.op == CXD_OP_WDT_CLEAR);
    wire logic [12:0] ret_addr = pc_r + CXD_ONE13; // [RULE3]
    wire logic [12:0] call_pc = {latch_r[4:3], insn_r.target}; // [RULE4]
    cxd_stack u_stack (
        .clk(MCLK),
        .rst(RST),
        .push(is_call),
        .push_addr(ret_addr),
        .top(STACK_TOP)
    );
    assign WDT_CLEAR = is_wdt; // [RULE1]
    assign WDT_PRESCALER_CLEAR = is_wdt; // [RULE1]
    assign PC = pc_r;

    //======================================================================
    // sequencing: call and a taken skip get a second cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CXD_IDLE: if (start) state_nxt = CXD_EXEC;
            CXD_EXEC: begin
                if (is_call || (exec && res.skip)) begin
                    state_nxt = CXD_SECOND; // [RULE5] [RULE12]
                end else begin
                    state_nxt = CXD_IDLE; // [RULE14]
                end
            end
            CXD_SECOND: state_nxt = CXD_IDLE;
            default: state_nxt = CXD_IDLE;
        endcase
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) state_r <= CXD_IDLE;
        else state_r <= state_nxt;
    end

    // instruction capture
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) insn_r <= '0;
        else if (start) insn_r <= new_insn;
    end

    // program counter: call jumps, skip advances an extra word, others step
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pc_r <= CXD_PC_RST;
        end else if (wr_take && hit_pc) begin
            pc_r <= AVS_WRITEDATA[12:0];
        end else if (is_call) begin
            pc_r <= call_pc; // [RULE4]
        end else if (exec || state_r == CXD_SECOND && insn_r.op == CXD_OP_DEC_SKIP) begin
            pc_r <= ret_addr; // [RULE12]
        end
    end

    // accumulator and pc high latch
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_r <= CXD_ACC_RST;
            latch_r <= CXD_LATCH_RST;
        end else begin
            if (wr_take && hit_acc) acc_r <= AVS_WRITEDATA[7:0];
            else if (exec && res.to_acc) acc_r <= res.value; // [RULE7] [RULE10]
            if (wr_take && hit_status && AVS_BYTEENABLE[1]) begin
                latch_r <= AVS_WRITEDATA[CXD_LATCH_LSB +: 8];
            end
        end
    end

    // status flags; calls and skips leave them alone
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            zero_r <= 1'b0;
            sleep_r <= 1'b1;
            expiry_r <= 1'b1;
        end else begin
            if (exec && res.zero_upd) begin
                zero_r <= (res.value == CXD_ZERO8); // [RULE13] [RULE8] [RULE10]
            end else if (wr_take && hit_status && AVS_BYTEENABLE[0]) begin
                zero_r <= AVS_WRITEDATA[CXD_ZERO_BIT];
            end
            if (is_wdt) begin
                sleep_r <= 1'b1; // [RULE2]
                expiry_r <= 1'b1; // [RULE2]
            end else if (wr_take && hit_status && AVS_BYTEENABLE[0]) begin
                sleep_r <= AVS_WRITEDATA[CXD_SLEEP_BIT];
                expiry_r <= AVS_WRITEDATA[CXD_EXPIRY_BIT];
            end
        end
    end

    // file register array; no reset, software must initialise it
    always_ff @(posedge MCLK) begin
        if (exec && res.to_file) file_mem[insn_r.file_addr] <= res.value; // [RULE6] [RULE9]
    end

    // registered read data, one wait cycle per read
    wire logic [31:0] status_word = {16'h0000, latch_r, 4'h0, busy, expiry_r, sleep_r, zero_r};
    wire logic [31:0] rd_mux = hit_acc ? {24'h000000, acc_r} : hit_status ? status_word :
        hit_pc ? {19'h00000, pc_r} : hit_insn ? {9'h000, insn_r} : 32'h00000000;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rdata_r <= 32'h00000000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rd_mux;
            rvalid_r <= AVS_READ && !rvalid_r;
        end
    end

    //======================================================================
    // assertions
    // call spends exactly one extra cycle before going idle
    a_call_two_cycles: assert property (@(posedge MCLK) disable iff (RST) // [RULE5]
        is_call |=> state_r == CXD_SECOND ##1 state_r == CXD_IDLE)
        else $error("call did not take two cycles");

    // call target: low bits from the word, top two from the latch
    a_call_pc_load: assert property (@(posedge MCLK) disable iff (RST) // [RULE4]
        is_call |=> pc_r == {$past(latch_r[4:3]), $past(insn_r.target)})
        else $error("call target wrong");

    // the return address is the word after the call
    a_call_push: assert property (@(posedge MCLK) disable iff (RST) // [RULE3]
        is_call |=> STACK_TOP == $past(pc_r) + CXD_ONE13)
        else $error("return address wrong");

    // a call touches no status flag
    a_call_flags: assert property (@(posedge MCLK) disable iff (RST) // [RULE5]
        is_call |=> $stable(zero_r) && $stable(sleep_r) && $stable(expiry_r))
        else $error("call changed a flag");

    // both clears pulse together, then both flags read one
    a_wdt_flags: assert property (@(posedge MCLK) disable iff (RST) // [RULE1] [RULE2]
        is_wdt |-> WDT_CLEAR && WDT_PRESCALER_CLEAR ##1 sleep_r && expiry_r)
        else $error("watchdog clear incomplete");

    // a held clear would freeze the counter, so the pulse is one cycle
    a_wdt_pulse: assert property (@(posedge MCLK) disable iff (RST) // [RULE1]
        WDT_CLEAR |=> !WDT_CLEAR && !WDT_PRESCALER_CLEAR)
        else $error("watchdog clear pulse too long");

    // watchdog clear leaves the zero flag alone
    a_wdt_zero_kept: assert property (@(posedge MCLK) disable iff (RST) // [RULE2]
        is_wdt |=> $stable(zero_r))
        else $error("watchdog clear changed zero flag");

    // zero flag follows the result of every op that updates it
    a_zero_rule: assert property (@(posedge MCLK) disable iff (RST) // [RULE13]
        exec && res.zero_upd |=> zero_r == ($past(res.value) == CXD_ZERO8))
        else $error("zero flag mismatch");

    // a nonzero result must clear the flag again
    a_zero_clear: assert property (@(posedge MCLK) disable iff (RST) // [RULE13]
        exec && res.zero_upd && res.value != CXD_ZERO8 |=> !zero_r)
        else $error("zero flag left set");

    // complement written back lands in the addressed register
    a_comp_file: assert property (@(posedge MCLK) disable iff (RST) // [RULE6]
        exec && insn_r.op == CXD_OP_COMPLEMENT && insn_r.dest |=> operand == ~$past(operand))
        else $error("complement to file wrong");

    // dest low: accumulator takes the result, register keeps its value
    a_comp_acc: assert property (@(posedge MCLK) disable iff (RST) // [RULE7]
        exec && insn_r.op == CXD_OP_COMPLEMENT && !insn_r.dest |=>
        acc_r == ~$past(operand) && $stable(operand))
        else $error("complement to accumulator wrong");

    // clear file zeroes the register and sets the flag
    a_clear_file: assert property (@(posedge MCLK) disable iff (RST) // [RULE8]
        exec && insn_r.op == CXD_OP_CLEAR_FILE |=> operand == CXD_ZERO8 && zero_r)
        else $error("clear file wrong");

    // decrement back into the register
    a_dec_file: assert property (@(posedge MCLK) disable iff (RST) // [RULE9]
        exec && insn_r.op == CXD_OP_DECREMENT && insn_r.dest |=>
        operand == $past(operand) - CXD_ONE8)
        else $error("decrement to file wrong");

    // decrement into the accumulator leaves the register as it was
    a_dec_acc: assert property (@(posedge MCLK) disable iff (RST) // [RULE9]
        exec && insn_r.op == CXD_OP_DECREMENT && !insn_r.dest |=>
        acc_r == $past(operand) - CXD_ONE8 && $stable(operand))
        else $error("decrement to accumulator wrong");

    // decrement-skip still writes its result
    a_skip_result: assert property (@(posedge MCLK) disable iff (RST) // [RULE11]
        exec && insn_r.op == CXD_OP_DEC_SKIP && insn_r.dest |=>
        operand == $past(operand) - CXD_ONE8)
        else $error("skip result wrong");

    // decrement-skip never moves the zero flag
    a_skip_flags: assert property (@(posedge MCLK) disable iff (RST) // [RULE11]
        exec && insn_r.op == CXD_OP_DEC_SKIP |=> $stable(zero_r))
        else $error("skip changed zero flag");

    // an operand of one decrements to zero and must skip
    a_skip_taken: assert property (@(posedge MCLK) disable iff (RST) // [RULE12]
        exec && insn_r.op == CXD_OP_DEC_SKIP && operand == CXD_ONE8 |=> state_r == CXD_SECOND)
        else $error("skip not taken");

    // any other operand lets the next word run
    a_skip_not_taken: assert property (@(posedge MCLK) disable iff (RST) // [RULE12]
        exec && insn_r.op == CXD_OP_DEC_SKIP && operand != CXD_ONE8 |=> state_r == CXD_IDLE)
        else $error("skip taken on nonzero result");

    // a taken skip moves the pc past the discarded word
    a_skip_pc: assert property (@(posedge MCLK) disable iff (RST) // [RULE12]
        exec && res.skip && !(wr_take && hit_pc) |=> ##1 pc_r == $past(pc_r, 2) + 13'h0002)
        else $error("skip did not discard next");

    // plain ops are done after one cycle
    a_single_cycle: assert property (@(posedge MCLK) disable iff (RST) // [RULE14]
        exec && !is_call && !res.skip |=> state_r == CXD_IDLE)
        else $error("op took too long");

    // plain ops advance the pc by exactly one word
    a_pc_step: assert property (@(posedge MCLK) disable iff (RST) // [RULE14]
        exec && !is_call && !res.skip |=> pc_r == $past(pc_r) + CXD_ONE13)
        else $error("pc step wrong");

    // clear accumulator zeroes it and sets the flag
    a_clear_acc: assert property (@(posedge MCLK) disable iff (RST) // [RULE10]
        exec && insn_r.op == CXD_OP_CLEAR_ACC |=> acc_r == CXD_ZERO8 && zero_r)
        else $error("clear accumulator wrong");
endmodule : cxd_exec
`default_nettype wire

// ===== test/cxd_wdt_model.sv
// watchdog counter model standing behind the exec block's clear pulses
`timescale 1ns/10ps
`default_nettype none
module cxd_wdt_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic pre_clr,
    output logic [7:0] count_r,
    output logic [7:0] pulses_r
);
    logic [3:0] pre_r;
    //========================================
    // counter and prescaler
    // prescale by 16 so a missed clear shows as a growing count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= 4'h0;
            count_r <= 8'h00;
            pulses_r <= 8'h00;
        end else begin
            pre_r <= pre_clr ? 4'h0 : pre_r + 4'h1;
            count_r <= clr ? 8'h00 : count_r + {7'h0, &pre_r};
            pulses_r <= pulses_r + {7'h0, clr & pre_clr};
        end
    end
endmodule : cxd_wdt_model
`default_nettype wire

// ===== test/test_cxd_exec.sv
// testbench for the exec block: bus driver, scenarios and verdict
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module test_cxd_exec
    import cxd_pkg::*;
;
    logic MCLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic [12:0] PC, STACK_TOP, pc_e = 13'h0;
    logic [7:0] wd_cnt, wd_pulses, latch_e = 8'h00;
    logic WDT_CLEAR, WDT_PRESCALER_CLEAR;
    int fail_count = 0, n_tests = 0;

    cxd_exec dut (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .WDT_CLEAR(WDT_CLEAR), .WDT_PRESCALER_CLEAR(WDT_PRESCALER_CLEAR),
        .PC(PC), .STACK_TOP(STACK_TOP));
    cxd_wdt_model wm (.clk(MCLK), .rst(RST), .clr(WDT_CLEAR), .pre_clr(WDT_PRESCALER_CLEAR),
        .count_r(wd_cnt), .pulses_r(wd_pulses));

    //========================================
    // clock and watchdog
    initial begin
        forever #10 MCLK = ~MCLK;
    end
    // whole run is a few hundred cycles, so this only trips on a hang
    initial begin
        repeat (5000) @(posedge MCLK);
        fail_count++;
        give_verdict();
    end

    //========================================
    // bus tasks
    // one access; hold leaves write up so a follower can go back to back
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic hold, output int waits);
        logic w;
        waits = 0;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        // waitrequest and read data are both taken at the same rising edge
        do begin
            @(posedge MCLK);
            w = AVS_WAITREQUEST;
            q = AVS_READDATA;
            if (w !== 1'b0) waits++;
        end while (w !== 1'b0);
        if (!hold) begin
            AVS_WRITE <= 1'b0;
            AVS_READ <= 1'b0;
            @(posedge MCLK);
        end
    endtask : bus

    task automatic rd(input logic [3:0] a);
        int w;
        bus(1'b0, a, 32'h0, 1'b0, w);
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int w;
        bus(1'b1, a, d, 1'b0, w);
    endtask : wr

    // run an op with a nop right behind; the nop's waits give the op's length
    task automatic op(input cxd_op_t o, input logic dd, input logic [6:0] f,
                      input logic [10:0] t, input int ew, input logic [7:0] acc_e,
                      input logic [2:0] fl_e);
        int w;
        bus(1'b1, CXD_OFF_INSN, {9'h0, o, dd, f, 1'b0, t}, 1'b1, w);
        bus(1'b1, CXD_OFF_INSN, 32'h0, 1'b0, w);
        `CHK(w, ew)
        pc_e = (o == CXD_OP_CALL) ? {latch_e[4:3], t} + 13'h1 : pc_e + ew[12:0] + 13'h1;
        do rd(CXD_OFF_STATUS); while (q[CXD_BUSY_BIT] === 1'b1);
        `CHK(q[2:0], fl_e)
        rd(CXD_OFF_ACC);
        `CHK(q[7:0], acc_e)
        `CHK(PC, pc_e)
    endtask : op

    //========================================
    // scenarios
    task automatic t_reset();
        rd(CXD_OFF_STATUS);
        `CHK(q, 32'h0000_0006)
        rd(CXD_OFF_PC);
        `CHK(q, 32'h0)
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2);
        `CHK(q, 32'h0)
        $display("reset values done");
    endtask : t_reset

    // file 127 walks 00, ff, fe, 01, then down through zero with skips
    task automatic t_file();
        op(CXD_OP_CLEAR_FILE, 1'b1, 7'h7f, 11'h0, 1, 8'h00, 3'b111);
        op(CXD_OP_COMPLEMENT, 1'b1, 7'h7f, 11'h0, 1, 8'h00, 3'b110);
        op(CXD_OP_COMPLEMENT, 1'b0, 7'h7f, 11'h0, 1, 8'h00, 3'b111);
        op(CXD_OP_DECREMENT, 1'b1, 7'h7f, 11'h0, 1, 8'h00, 3'b110);
        op(CXD_OP_COMPLEMENT, 1'b0, 7'h7f, 11'h0, 1, 8'h01, 3'b110);
        op(CXD_OP_COMPLEMENT, 1'b1, 7'h7f, 11'h0, 1, 8'h01, 3'b110);
        op(CXD_OP_DECREMENT, 1'b0, 7'h7f, 11'h0, 1, 8'h00, 3'b111);
        op(CXD_OP_DEC_SKIP, 1'b0, 7'h7f, 11'h0, 2, 8'h00, 3'b111);
        wr(CXD_OFF_STATUS, 32'h0000_0006);
        op(CXD_OP_DEC_SKIP, 1'b1, 7'h7f, 11'h0, 2, 8'h00, 3'b110);
        op(CXD_OP_DEC_SKIP, 1'b1, 7'h7f, 11'h0, 1, 8'h00, 3'b110);
        op(CXD_OP_COMPLEMENT, 1'b0, 7'h7f, 11'h0, 1, 8'h00, 3'b111);
        $display("file ops done");
    endtask : t_file

    // latch f7 puts 10 in bits 4:3; other latch bits must not leak into pc
    task automatic t_call();
        wr(CXD_OFF_STATUS, 32'h0000_f701);
        latch_e = 8'hf7;
        wr(CXD_OFF_PC, 32'h0000_0123);
        pc_e = 13'h0123;
        op(CXD_OP_CALL, 1'b0, 7'h0, 11'h7ff, 2, 8'h00, 3'b001);
        `CHK(STACK_TOP, 13'h0124)
        $display("call done");
    endtask : t_call

    task automatic t_wdt_acc();
        logic [7:0] p0;
        wr(CXD_OFF_STATUS, 32'h0);
        p0 = wd_pulses;
        op(CXD_OP_WDT_CLEAR, 1'b0, 7'h0, 11'h0, 1, 8'h00, 3'b110);
        `CHK(wd_pulses, p0 + 8'h1)
        `CHK(wd_cnt < 8'h08, 1'b1)
        wr(CXD_OFF_ACC, 32'h0000_005a);
        op(CXD_OP_CLEAR_ACC, 1'b0, 7'h0, 11'h0, 1, 8'h00, 3'b111);
        $display("watchdog and accumulator done");
    endtask : t_wdt_acc

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    //========================================
    // main sequence
    initial begin
        repeat (4) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        t_reset();
        t_file();
        t_call();
        t_wdt_acc();
        give_verdict();
    end
endmodule : test_cxd_exec
`default_nettype wire
